/* File: hdl/hbs_params.svh */
// timing, encoding and offset constants of the boot mode sequencer
`ifndef HBS_PARAMS_SVH
`define HBS_PARAMS_SVH

`define HBS_CLK_PERIOD_NS        8
`define HBS_REG_SETTLE_NS        20000
`define HBS_REG_SETTLE_CYC       ((`HBS_REG_SETTLE_NS + `HBS_CLK_PERIOD_NS - 1) / `HBS_CLK_PERIOD_NS)
`define HBS_BUS_SENSE_NS         1000
`define HBS_BUS_SENSE_CYC        ((`HBS_BUS_SENSE_NS + `HBS_CLK_PERIOD_NS - 1) / `HBS_CLK_PERIOD_NS)
`define HBS_CNT_W                16
`define HBS_CFG_DONE_ADDR        8'hFF
`define HBS_CFGSEL_SELF          2'h0
`define HBS_CFGSEL_SMB           2'h1
`define HBS_CFGSEL_BUS           2'h2
`define HBS_CFGSEL_I2C           2'h3

`endif

/* File: hdl/hbs_pkg.sv */
// types of the boot mode sequencer
package hbs_pkg;
    typedef enum logic [3:0] {
        HBS_STANDBY,
        HBS_HARDWARE_INIT_STAGE,
        HBS_FIRMWARE_INIT_STAGE,
        HBS_BUS_SENSE,
        HBS_SOC_CFG,
        HBS_CONFIG,
        HBS_IDLE_SUSPEND,
        HBS_CHARGER_DETECT_STAGE,
        HBS_HUB_CONNECT,
        HBS_NORMAL
    } hbs_stage_t;
endpackage : hbs_pkg

/* File: hdl/hbs_boot_sequencer.sv */
// boot mode and stage sequencer of the four port hub
`timescale 1ns/1ns
`default_nettype none
`include "hbs_params.svh"

// Contract
// - reset low holds standby, watching reset only
// - standby tristates ports, powers off regulators, pll
// - reset high runs hub mode
// - standby keeps nothing; reinitialize after reset
// - hardware init enables regulator, resets, locks pll
// - hardware init loads defaults, captures straps
// - no bus response during hardware init
// - init done with clock advances to firmware init
// - i2c master straps load from external rom
// - data low or straps 00/10: sense bus with pull-downs
// - bus detected enters soc configuration
// - soc configuration accepts changes, no timeout
// - configuration merges defaults, soc, otp data
// - idle then suspend without vbus or connect
// - vbus and detect enabled enter charger detect
// - vbus, detect disabled go to hub connect
// - charger detect starts automatically, then connect
// - normal mode until mode change or reset
// - soft disconnect returns to hub connect
// - no bus service in suspend unless awake
// - suspend clock keep holds bus awake
// - data high, straps 11: eeprom load
// - data high, straps 01: wait soc master
module hbs_boot_sequencer #(
    parameter int REG_SETTLE_CYC = `HBS_REG_SETTLE_CYC,
    parameter int BUS_SENSE_CYC  = `HBS_BUS_SENSE_CYC
) (
    input  wire logic       mclk_in,
    input  wire logic       rstn_in,
    input  wire logic       reset_pin_n_in,
    input  wire logic       reference_clock_in,
    input  wire logic       pll_locked_in,
    input  wire logic       regulator_good_in,
    input  wire logic [1:0] cfg_sel_in,
    input  wire logic       sda_in,
    input  wire logic       scl_in,
    input  wire logic       vbus_in,
    input  wire logic       hub_connect_req_in,
    input  wire logic       soft_disconnect_in,
    input  wire logic       usb_suspend_in,
    input  wire logic       eeprom_load_done_in,
    input  wire logic       merge_done_in,
    input  wire logic       charger_detect_done_in,
    input  wire logic       reg_wr_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic       reg_wdata_chg_en_in,
    input  wire logic       reg_wdata_clk_keep_in,
    input  wire logic       reg_wr_cfg_in,
    output logic            regulator_en_out,
    output logic            pll_en_out,
    output logic            core_rst_out,
    output logic            port_oe_out,
    output logic            load_defaults_out,
    output logic            bus_pulldown_en_out,
    output logic            eeprom_load_out,
    output logic            merge_start_out,
    output logic            charger_detect_start_out,
    output logic            hub_attach_out,
    output logic            bus_serve_en_out,
    output logic            suspended_out,
    output logic [1:0]      strap_cfg_sel_out,
    output logic            strap_sda_out,
    output logic            chg_detect_en_out,
    output logic            suspend_clock_keep_out,
    output logic [3:0]      stage_out
);

    hbs_pkg::hbs_stage_t stage;
    hbs_pkg::hbs_stage_t next_stage;
    logic [`HBS_CNT_W-1:0] settle_cnt;
    logic [`HBS_CNT_W-1:0] sense_cnt;
    logic                  settle_done;
    logic                  sense_done;
    logic                  bus_seen;
    logic                  cfg_done_wr;
    logic                  clk_present;
    logic                  i2c_load;
    logic                  soc_wait;
    logic                  chg_detect_en;
    logic                  suspend_clock_keep;

    assign clk_present = reference_clock_in & pll_locked_in;
    assign settle_done = (settle_cnt >= REG_SETTLE_CYC[`HBS_CNT_W-1:0]) & regulator_good_in;
    assign sense_done  = (sense_cnt >= BUS_SENSE_CYC[`HBS_CNT_W-1:0]);
    // strap decode with data line as qualifier
    assign i2c_load = strap_sda_out & (strap_cfg_sel_out == `HBS_CFGSEL_I2C);
    assign soc_wait = strap_sda_out & (strap_cfg_sel_out == `HBS_CFGSEL_SMB);
    // write to the done address, only while the soc configures
    assign cfg_done_wr = reg_wr_in & (reg_addr_in == `HBS_CFG_DONE_ADDR)
                       & (stage == hbs_pkg::HBS_SOC_CFG);

    always_comb begin
        next_stage = stage;
        unique case (stage)
            hbs_pkg::HBS_STANDBY: begin
                if (reset_pin_n_in) begin
                    next_stage = hbs_pkg::HBS_HARDWARE_INIT_STAGE;
                end
            end
            hbs_pkg::HBS_HARDWARE_INIT_STAGE: begin
                if (settle_done && clk_present) begin
                    next_stage = hbs_pkg::HBS_FIRMWARE_INIT_STAGE;
                end
            end
            hbs_pkg::HBS_FIRMWARE_INIT_STAGE: begin
                if (i2c_load) begin
                    next_stage = hbs_pkg::HBS_CONFIG;
                end else if (soc_wait) begin
                    next_stage = hbs_pkg::HBS_SOC_CFG;
                end else begin
                    next_stage = hbs_pkg::HBS_BUS_SENSE;
                end
            end
            hbs_pkg::HBS_BUS_SENSE: begin
                if (sense_done) begin
                    next_stage = bus_seen ? hbs_pkg::HBS_SOC_CFG
                                          : hbs_pkg::HBS_CONFIG;
                end
            end
            hbs_pkg::HBS_SOC_CFG: begin
                if (cfg_done_wr) begin
                    next_stage = hbs_pkg::HBS_CONFIG;
                end
            end
            hbs_pkg::HBS_CONFIG: begin
                if (merge_done_in && (!i2c_load || eeprom_load_done_in)) begin
                    next_stage = hbs_pkg::HBS_IDLE_SUSPEND;
                end
            end
            hbs_pkg::HBS_IDLE_SUSPEND: begin
                if (vbus_in && chg_detect_en) begin
                    next_stage = hbs_pkg::HBS_CHARGER_DETECT_STAGE;
                end else if (vbus_in || hub_connect_req_in) begin
                    next_stage = hbs_pkg::HBS_HUB_CONNECT;
                end
            end
            hbs_pkg::HBS_CHARGER_DETECT_STAGE: begin
                if (!chg_detect_en || charger_detect_done_in) begin
                    next_stage = hbs_pkg::HBS_HUB_CONNECT;
                end
            end
            hbs_pkg::HBS_HUB_CONNECT: begin
                if (!soft_disconnect_in) begin
                    next_stage = hbs_pkg::HBS_NORMAL;
                end
            end
            hbs_pkg::HBS_NORMAL: begin
                if (soft_disconnect_in) begin
                    next_stage = hbs_pkg::HBS_HUB_CONNECT;
                end
            end
            default: next_stage = hbs_pkg::HBS_STANDBY;
        endcase
        if (!reset_pin_n_in) begin
            next_stage = hbs_pkg::HBS_STANDBY;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            stage <= hbs_pkg::HBS_STANDBY;
        end else begin
            stage <= next_stage;
        end
    end

    // regulator settle count
    always_ff @(posedge mclk_in) begin
        if (!rstn_in || stage != hbs_pkg::HBS_HARDWARE_INIT_STAGE) begin
            settle_cnt <= '0;
        end else if (!settle_done) begin
            settle_cnt <= settle_cnt + 1'b1;
        end
    end

    // bus presence sense window
    always_ff @(posedge mclk_in) begin
        if (!rstn_in || stage != hbs_pkg::HBS_BUS_SENSE) begin
            sense_cnt <= '0;
            bus_seen  <= 1'b1;
        end else if (!sense_done) begin
            sense_cnt <= sense_cnt + 1'b1;
            bus_seen  <= bus_seen & sda_in & scl_in;
        end
    end

    // strap capture during hardware init
    always_ff @(posedge mclk_in) begin
        if (!rstn_in || stage == hbs_pkg::HBS_STANDBY) begin
            strap_cfg_sel_out <= `HBS_CFGSEL_SELF;
            strap_sda_out     <= 1'b0;
        end else if (stage == hbs_pkg::HBS_HARDWARE_INIT_STAGE) begin
            strap_cfg_sel_out <= cfg_sel_in;
            strap_sda_out     <= sda_in;
        end
    end

    // soc writable configuration bits
    always_ff @(posedge mclk_in) begin
        if (!rstn_in || stage == hbs_pkg::HBS_STANDBY
            || stage == hbs_pkg::HBS_HARDWARE_INIT_STAGE) begin
            chg_detect_en      <= 1'b1;
            suspend_clock_keep <= 1'b0;
        end else if (reg_wr_in && reg_wr_cfg_in && bus_serve_en_out) begin
            chg_detect_en      <= reg_wdata_chg_en_in;
            suspend_clock_keep <= reg_wdata_clk_keep_in;
        end
    end

    // one-cycle start pulses on stage entry
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            merge_start_out          <= 1'b0;
            charger_detect_start_out <= 1'b0;
        end else begin
            merge_start_out <= (next_stage == hbs_pkg::HBS_CONFIG)
                             && (stage != hbs_pkg::HBS_CONFIG);
            charger_detect_start_out <= (next_stage == hbs_pkg::HBS_CHARGER_DETECT_STAGE)
                             && (stage != hbs_pkg::HBS_CHARGER_DETECT_STAGE)
                             && chg_detect_en;
        end
    end

    assign regulator_en_out    = (stage != hbs_pkg::HBS_STANDBY);
    assign pll_en_out          = (stage != hbs_pkg::HBS_STANDBY);
    assign core_rst_out        = (stage == hbs_pkg::HBS_STANDBY)
                               || (stage == hbs_pkg::HBS_HARDWARE_INIT_STAGE);
    assign port_oe_out         = (stage != hbs_pkg::HBS_STANDBY);
    assign load_defaults_out   = (stage == hbs_pkg::HBS_HARDWARE_INIT_STAGE);
    assign bus_pulldown_en_out = (stage == hbs_pkg::HBS_BUS_SENSE);
    assign eeprom_load_out     = (stage == hbs_pkg::HBS_CONFIG) && i2c_load;
    assign hub_attach_out      = (stage == hbs_pkg::HBS_NORMAL);
    assign suspended_out       = usb_suspend_in && (stage == hbs_pkg::HBS_NORMAL
                               || stage == hbs_pkg::HBS_IDLE_SUSPEND);
    assign bus_serve_en_out    = (stage != hbs_pkg::HBS_STANDBY)
                               && (stage != hbs_pkg::HBS_HARDWARE_INIT_STAGE)
                               && (stage != hbs_pkg::HBS_BUS_SENSE)
                               && (!suspended_out || suspend_clock_keep);
    assign chg_detect_en_out      = chg_detect_en;
    assign suspend_clock_keep_out = suspend_clock_keep;
    assign stage_out              = stage;

endmodule : hbs_boot_sequencer
`default_nettype wire

/* File: sim/hbs_boot_monitor.sv */
// port assertions of the boot mode sequencer
`timescale 1ns/1ns
`default_nettype none
module hbs_boot_monitor (
    input wire logic       mclk_in,
    input wire logic       rstn_in,
    input wire logic       reset_pin_n_in,
    input wire logic       reference_clock_in,
    input wire logic       soft_disconnect_in,
    input wire logic       reg_wr_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic       regulator_en_out,
    input wire logic       port_oe_out,
    input wire logic       load_defaults_out,
    input wire logic       bus_serve_en_out,
    input wire logic       suspended_out,
    input wire logic       suspend_clock_keep_out,
    input wire logic [3:0] stage_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);
    wire done_wr = reg_wr_in && reg_addr_in == 8'hFF;
    wire run4    = stage_out == 4'h4 && reset_pin_n_in;
    a_standby_hold: assert property (!reset_pin_n_in |=> stage_out == 4'h0)
        else $error("stage left standby");
    a_standby_off: assert property (stage_out == 4'h0 |-> !(regulator_en_out | port_oe_out))
        else $error("powered in standby");
    a_init_quiet: assert property (stage_out == 4'h1 |-> load_defaults_out && !bus_serve_en_out)
        else $error("bus served in init");
    a_wake_init: assert property (stage_out == 4'h0 && reset_pin_n_in |=> stage_out == 4'h1)
        else $error("no init after reset");
    a_clock_wait: assert property (stage_out == 4'h1 && reset_pin_n_in && !reference_clock_in
        |=> stage_out == 4'h1) else $error("init left without clock");
    a_soc_wait: assert property (run4 && !done_wr |=> stage_out == 4'h4)
        else $error("soc stage timed out");
    a_soc_done: assert property (run4 && done_wr |=> stage_out == 4'h5)
        else $error("end write ignored");
    a_soft_disc: assert property (stage_out == 4'h9 && soft_disconnect_in && reset_pin_n_in
        |=> stage_out == 4'h8) else $error("soft disconnect ignored");
    a_suspend_mute: assert property (suspended_out && !suspend_clock_keep_out
        |-> !bus_serve_en_out) else $error("bus served in suspend");
    c_normal: cover property (stage_out == 4'h9);
    c_charger: cover property (stage_out == 4'h7);
    c_soc_write: cover property (run4 && reg_wr_in);
endmodule : hbs_boot_monitor
bind hbs_boot_sequencer hbs_boot_monitor u_hbs_boot_monitor (.mclk_in, .rstn_in,
    .reset_pin_n_in, .reference_clock_in, .soft_disconnect_in, .reg_wr_in, .reg_addr_in,
    .regulator_en_out, .port_oe_out, .load_defaults_out, .bus_serve_en_out,
    .suspended_out, .suspend_clock_keep_out, .stage_out);
`default_nettype wire

/* File: sim/hbs_soc_model.sv */
// soc side model: bus pull-ups and register writes
`timescale 1ns/1ns
`default_nettype none
module hbs_soc_model (
    input  wire logic       mclk_in,
    input  wire logic       bus_present_in,
    output logic            sda_out,
    output logic            scl_out,
    output logic            wr_out,
    output logic [7:0]      addr_out,
    output logic            cfg_out,
    output logic            chg_en_out,
    output logic            keep_out
);
    // external pull-ups beat the sense pull-downs
    assign sda_out = bus_present_in;
    assign scl_out = bus_present_in;
    initial {wr_out, addr_out, cfg_out, chg_en_out, keep_out} = 12'h000;
    task automatic write_reg(input logic [7:0] a, input logic c, input logic e, input logic k);
        @(posedge mclk_in);
        #1;
        {wr_out, addr_out, cfg_out, chg_en_out, keep_out} = {1'b1, a, c, e, k};
        @(posedge mclk_in);
        #1;
        {wr_out, addr_out, cfg_out, chg_en_out, keep_out} = {1'b0, ~a, 1'b0, ~e, ~k};
    endtask : write_reg
endmodule : hbs_soc_model
`default_nettype wire

/* File: sim/tb_top.sv */
// self-checking bench of the boot mode sequencer
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module tb_top;
    logic mclk_in = 1'b0, rstn_in = 1'b0, reset_pin_n_in = 1'b0, reference_clock_in = 1'b0;
    logic vbus_in = 1'b0, usb_suspend_in = 1'b0, soft_disconnect_in = 1'b1, present = 1'b1;
    logic eeprom_load_done_in = 1'b0, merge_done_in = 1'b0, charger_detect_done_in = 1'b0;
    logic [1:0] cfg_sel_in = 2'h1;
    logic [1:0] strap_cfg_sel_out;
    logic [7:0] reg_addr_in;
    logic [3:0] stage_out;
    logic sda_in, scl_in, reg_wr_in, reg_wr_cfg_in, reg_wdata_chg_en_in, reg_wdata_clk_keep_in;
    logic regulator_en_out, port_oe_out, load_defaults_out, bus_serve_en_out, hub_attach_out;
    logic eeprom_load_out, suspended_out, chg_detect_en_out, suspend_clock_keep_out;
    logic strap_sda_out, bus_pulldown_en_out;
    logic pll_en_out, core_rst_out, merge_start_out, charger_detect_start_out;
    logic hub_connect_req_in = 1'b0;
    int   err_count = 0;
    int   cmp_count = 0;
    always #4 mclk_in = ~mclk_in;
    hbs_soc_model u_hbs_soc_model (.mclk_in, .bus_present_in(present), .sda_out(sda_in),
        .scl_out(scl_in), .wr_out(reg_wr_in), .addr_out(reg_addr_in), .cfg_out(reg_wr_cfg_in),
        .chg_en_out(reg_wdata_chg_en_in), .keep_out(reg_wdata_clk_keep_in));
    hbs_boot_sequencer #(.REG_SETTLE_CYC(4), .BUS_SENSE_CYC(4)) u_hbs_boot_sequencer (
        .mclk_in, .rstn_in, .reset_pin_n_in, .reference_clock_in, .cfg_sel_in, .sda_in, .scl_in,
        .pll_locked_in(reference_clock_in), .regulator_good_in(reference_clock_in), .vbus_in,
        .hub_connect_req_in, .soft_disconnect_in, .usb_suspend_in, .eeprom_load_done_in,
        .merge_done_in, .charger_detect_done_in, .reg_wr_in, .reg_addr_in, .reg_wr_cfg_in,
        .reg_wdata_chg_en_in, .reg_wdata_clk_keep_in, .regulator_en_out, .pll_en_out,
        .core_rst_out, .port_oe_out, .load_defaults_out, .bus_pulldown_en_out,
        .eeprom_load_out, .merge_start_out, .charger_detect_start_out, .hub_attach_out,
        .bus_serve_en_out, .suspended_out, .strap_cfg_sel_out, .strap_sda_out,
        .chg_detect_en_out, .suspend_clock_keep_out, .stage_out);
    task automatic step(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask : step
    task automatic wait_stage(input logic [3:0] s);
        for (int k = 0; k < 100 && stage_out !== s; k++) step(1);
        `CHK("stage", s, stage_out)
    endtask : wait_stage
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : give_verdict
    initial begin
        #100000;
        err_count++;
        give_verdict();
    end
    initial begin
        step(4);
        rstn_in = 1'b1;
        step(3);
        `CHK("standby", 4'h0, stage_out)
        `CHK("power", 3'h0, {regulator_en_out, port_oe_out, pll_en_out})
        reset_pin_n_in = 1'b1;
        step(12);
        `CHK("init", 4'hB, {stage_out == 4'h1, bus_serve_en_out, load_defaults_out, core_rst_out})
        reference_clock_in = 1'b1;
        wait_stage(4'h2);
        wait_stage(4'h4);
        `CHK("straps", 3'h5, {strap_sda_out, strap_cfg_sel_out})
        u_hbs_soc_model.write_reg(8'h01, 1'b1, 1'b0, 1'b1);
        step(6);
        `CHK("soc wait", 4'h4, stage_out)
        u_hbs_soc_model.write_reg(8'hFF, 1'b0, 1'b0, 1'b0);
        wait_stage(4'h5);
        `CHK("merge start", 3'h5, {merge_start_out, core_rst_out, pll_en_out})
        merge_done_in = 1'b1;
        vbus_in = 1'b1;
        wait_stage(4'h8);
        soft_disconnect_in = 1'b0;
        wait_stage(4'h9);
        `CHK("attach", 1'b1, hub_attach_out)
        soft_disconnect_in = 1'b1;
        wait_stage(4'h8);
        soft_disconnect_in = 1'b0;
        usb_suspend_in = 1'b1;
        wait_stage(4'h9);
        `CHK("awake", 3'h7, {suspended_out, suspend_clock_keep_out, bus_serve_en_out})
        {reset_pin_n_in, usb_suspend_in, vbus_in, cfg_sel_in, eeprom_load_done_in} = 6'h07;
        wait_stage(4'h0);
        reset_pin_n_in = 1'b1;
        wait_stage(4'h2);
        `CHK("reinit", 2'h2, {chg_detect_en_out, suspend_clock_keep_out})
        wait_stage(4'h5);
        `CHK("rom load", 1'b1, eeprom_load_out)
        wait_stage(4'h6);
        step(3);
        `CHK("idle", 4'h6, stage_out)
        vbus_in = 1'b1;
        wait_stage(4'h7);
        `CHK("chg start", 1'b1, charger_detect_start_out)
        charger_detect_done_in = 1'b1;
        wait_stage(4'h9);
        usb_suspend_in = 1'b1;
        step(1);
        `CHK("asleep", 2'h2, {suspended_out, bus_serve_en_out})
        for (int i = 0; i < 2; i++) begin
            {reset_pin_n_in, cfg_sel_in, present, vbus_in, hub_connect_req_in} = {3'h0, i[0], 2'h1};
            step(2);
            reset_pin_n_in = 1'b1;
            wait_stage(4'h3);
            `CHK("pulldown", 1'b1, bus_pulldown_en_out)
            wait_stage(i[0] ? 4'h4 : 4'h5);
            if (!i[0]) wait_stage(4'h8);
        end
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
